/* inc/epis_pkg.sv */
package epis_pkg;
   // Byte addresses on the Wishbone slave
   localparam logic [3:0] ADDR_SENSE = 4'h0;
   localparam logic [3:0] ADDR_CSR = 4'h4;
   localparam logic [3:0] ADDR_ENABLE = 4'h8;
   localparam logic [3:0] ADDR_FLAG = 4'hc;
   // Sense select field positions
   localparam int SENSE_FIRST_LO = 0;
   localparam int SENSE_SECOND_LO = 2;
   // Third pin edge select in control-and-status
   localparam int SENSE_THIRD_BIT = 6;
   // Enable and flag layout
   localparam int BIT_SECOND = 7;
   localparam int BIT_FIRST = 6;
   localparam int BIT_THIRD = 5;
   localparam int BIT_GLOBAL = 0;
   localparam logic [7:0] SENSE_RESET = 8'h00;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   // Sense codes
   localparam logic [1:0] SENSE_LOW = 2'h0;
   localparam logic [1:0] SENSE_ANY = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;
   // Wake sampling: slow oscillator period, in ns, and cycles of clk_sys
   localparam int CLK_NS = 25;
   localparam int WDOG_PERIOD_NS = 1000;
   localparam int WDOG_CYCLES = WDOG_PERIOD_NS / CLK_NS;
   localparam int WAKE_SAMPLES = 2;
endpackage

/* hw/epis_core.sv */
// How it works
// - A pin that is enabled raises its request even when it is driven as an output.
// - The third pin is edge only; the first two offer low level and both edges.
// - In low-level mode the first two pins request while the pin stays low.
// - Edges on the first two pins are found only while the I/O clock runs.
// - Low level on pins one and two and edges on pin three work with no I/O clock.
// - A level wake needs two samples of the low level on the slow wake tick.
// - A wake whose level drops before start-up ends wakes but raises nothing.
// - A pin interrupt goes out only with the global and the pin enable set.
// - Bits 3:2 pick the second pin mode: low, any change, fall, rise.
// - Bits 1:0 pick the first pin mode with the same encoding.
// - Pins are sampled before edge detection, so a pulse over one clock counts.
// - Bit 6 of control-and-status picks fall (0) or rise (1) for pin three.
// - A request flag sets on its trigger and clears on service or a written one.
// - A pin in low-level mode always reads its request flag as clear.
// - Enables sit at bit 7 (second), bit 6 (first) and bit 5 (third).
module epis_core
   import epis_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic io_clk_run,
   input wire logic sleep_deep,
   input wire logic startup_done,
   input wire logic ext_irq_pin_first,
   input wire logic ext_irq_pin_second,
   input wire logic ext_irq_pin_third,
   input wire logic [2:0] irq_serviced,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [2:0] irq_req,
   output logic irq_o,
   output logic wake_o
);
   logic [7:0] sense_reg;
   logic [7:0] csr_reg;
   logic [7:0] enable_reg;
   logic [2:0] flag_reg;
   logic [2:0] meta_reg;
   logic [2:0] sync_reg;
   logic [2:0] prev_reg;
   logic [2:0] level_low;
   logic [2:0] edge_hit;
   logic [2:0] pin_en;
   logic [2:0] flag_clr;
   logic [2:0] flag_view;
   logic [5:0] tick_reg;
   logic tick;
   logic [1:0] wake_cnt_reg;
   logic wake_reg;
   logic [2:0] irq_req_reg;
   logic irq_reg;
   logic ack_reg;
   logic [31:0] dat_reg;
   logic wb_hit;
   logic wr_sense;
   logic wr_csr;
   logic wr_en;
   logic wr_flag;
   logic [1:0] mode_first;
   logic [1:0] mode_second;

   assign mode_first = sense_reg[SENSE_FIRST_LO +: 2];
   assign mode_second = sense_reg[SENSE_SECOND_LO +: 2];
   assign wb_hit = wb_cyc_i && wb_stb_i && !ack_reg && wb_sel_i[0];
   assign wr_sense = wb_hit && wb_we_i && wb_adr_i == ADDR_SENSE;
   assign wr_csr = wb_hit && wb_we_i && wb_adr_i == ADDR_CSR;
   assign wr_en = wb_hit && wb_we_i && wb_adr_i == ADDR_ENABLE;
   assign wr_flag = wb_hit && wb_we_i && wb_adr_i == ADDR_FLAG;

   // Pins pass two flops; the pin's direction is never looked at
   // output pins still trigger
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= 3'h7;
         sync_reg <= 3'h7;
         prev_reg <= 3'h7;
      end else if (clk_en) begin
         meta_reg <= {ext_irq_pin_third, ext_irq_pin_second,
                      ext_irq_pin_first};
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   function automatic logic sense_hit(input logic [1:0] mode,
                                      input logic cur, input logic prv);
      logic hit;
      hit = 1'b0;
      unique case (mode)
         SENSE_LOW: hit = 1'b0;
         SENSE_ANY: hit = cur ^ prv;
         SENSE_FALL: hit = prv && !cur;
         SENSE_RISE: hit = cur && !prv;
      endcase
      return hit;
   endfunction

   always_comb begin
      edge_hit[0] = io_clk_run &&
                    sense_hit(mode_first, sync_reg[0], prev_reg[0]);
      edge_hit[1] = io_clk_run &&
                    sense_hit(mode_second, sync_reg[1], prev_reg[1]);
      // third pin edge needs no I/O clock
      edge_hit[2] = csr_reg[SENSE_THIRD_BIT] ?
                    (sync_reg[2] && !prev_reg[2]) :
                    (prev_reg[2] && !sync_reg[2]);
      level_low[0] = mode_first == SENSE_LOW && !sync_reg[0];
      level_low[1] = mode_second == SENSE_LOW && !sync_reg[1];
      level_low[2] = 1'b0;
   end

   assign pin_en = {enable_reg[BIT_THIRD], enable_reg[BIT_SECOND],
                    enable_reg[BIT_FIRST]};
   assign flag_clr = irq_serviced |
                     (wr_flag ? {wb_dat_i[BIT_THIRD], wb_dat_i[BIT_SECOND],
                                 wb_dat_i[BIT_FIRST]} : 3'h0);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         flag_reg <= 3'h0;
      end else if (clk_en) begin
         flag_reg <= edge_hit | (flag_reg & ~flag_clr);
      end
   end

   assign flag_view = flag_reg & ~level_low & {1'b1,
                      mode_second != SENSE_LOW, mode_first != SENSE_LOW};

   // Slow tick stands in for the watchdog oscillator
   assign tick = tick_reg == 6'(WDOG_CYCLES - 1);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tick_reg <= 6'h00;
      end else if (clk_en) begin
         tick_reg <= tick ? 6'h00 : tick_reg + 6'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wake_cnt_reg <= 2'h0;
         wake_reg <= 1'b0;
      end else if (clk_en) begin
         if (!sleep_deep) begin
            wake_cnt_reg <= 2'h0;
            wake_reg <= 1'b0;
         end else if (tick) begin
            if (|(level_low[1:0] & pin_en[1:0])) begin
               if (wake_cnt_reg == 2'(WAKE_SAMPLES - 1))
                  wake_reg <= 1'b1;
               else
                  wake_cnt_reg <= wake_cnt_reg + 2'h1;
            end else begin
               wake_cnt_reg <= 2'h0;
            end
         end
         if (sleep_deep && pin_en[2] && edge_hit[2])
            wake_reg <= 1'b1;
      end
   end

   // level must still be low here
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_req_reg <= 3'h0;
         irq_reg <= 1'b0;
      end else if (clk_en) begin
         irq_req_reg <= (flag_view | level_low) & pin_en &
                        {3{enable_reg[BIT_GLOBAL] && startup_done}};
         irq_reg <= |((flag_view | level_low) & pin_en) &&
                    enable_reg[BIT_GLOBAL] && startup_done;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sense_reg <= SENSE_RESET;
         csr_reg <= SENSE_RESET;
         enable_reg <= ENABLE_RESET;
      end else if (clk_en) begin
         if (wr_sense)
            sense_reg <= wb_dat_i[7:0];
         if (wr_csr)
            csr_reg <= wb_dat_i[7:0];
         if (wr_en)
            enable_reg <= wb_dat_i[7:0];
      end
   end

   // One wait cycle; unmapped reads give zero and writes vanish
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0;
      end else if (clk_en) begin
         ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
         dat_reg <= 32'h0;
         if (wb_cyc_i && wb_stb_i && !ack_reg) begin
            unique case (wb_adr_i)
               ADDR_SENSE: dat_reg <= {24'h0, sense_reg};
               ADDR_CSR: dat_reg <= {24'h0, csr_reg};
               ADDR_ENABLE: dat_reg <= {24'h0, enable_reg};
               ADDR_FLAG: dat_reg <= {24'h0, flag_view[1],
                                      flag_view[0], flag_view[2], 5'h0};
               default: dat_reg <= 32'h0;
            endcase
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign irq_req = irq_req_reg;
   assign irq_o = irq_reg;
   assign wake_o = wake_reg;

   a_global_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clk_en && !enable_reg[BIT_GLOBAL] |=> !irq_o)
      else $error("interrupt out with global enable clear");
   a_level_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clk_en && level_low[0] && pin_en[0] && enable_reg[BIT_GLOBAL]
      && startup_done |=> irq_req[0])
      else $error("level request missing");
   a_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clk_en && edge_hit[2] |=> flag_reg[2])
      else $error("edge lost");
   a_level_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
      mode_first == SENSE_LOW |-> !flag_view[0])
      else $error("flag visible in level mode");
   // no pin one edge without I/O clock
   a_io_clock: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !io_clk_run |-> !edge_hit[0] && !edge_hit[1])
      else $error("edge seen without I/O clock");
   a_third_rise: assert property (@(posedge clk_sys) disable iff (!rst_b)
      csr_reg[SENSE_THIRD_BIT] && $fell(sync_reg[2]) |-> !edge_hit[2])
      else $error("fall seen in rise mode");
   a_startup_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clk_en && !startup_done |=> irq_req == 3'h0)
      else $error("request during start-up");
   // wake only with deep sleep set on the cycle before
   a_wake_late: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(wake_o) |-> $past(sleep_deep))
      else $error("wake outside deep sleep");
   // synced pin rise is an edge
   a_edge_delay: assert property (@(posedge clk_sys) disable iff (!rst_b)
      clk_en && io_clk_run && mode_first == SENSE_RISE
      && $rose(sync_reg[0]) |-> edge_hit[0])
      else $error("rising edge missed");
endmodule // epis_core

/* dv/epis_pin_src.sv */
module epis_pin_src (
   input wire logic clk_sys,
   output logic pin_first,
   output logic pin_second,
   output logic pin_third
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pins idle high, as with a pull-up on each line
   logic [2:0] pins_reg = 3'h7;
   // levels change only on a clock edge and are held until told
   task automatic drive(input int idx, input logic lvl);
      @(posedge clk_sys);
      pins_reg[idx] <= lvl;
   endtask
   assign pin_first = pins_reg[0];
   assign pin_second = pins_reg[1];
   assign pin_third = pins_reg[2];
endmodule // epis_pin_src

/* dv/external_pin_interrupt_sense_test.sv */
module external_pin_interrupt_sense_test;
   timeunit 1ns;
   timeprecision 1ps;
   import epis_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic io_clk_run = 1'b1;
   logic sleep_deep = 1'b0;
   logic startup_done = 1'b1;
   logic [2:0] irq_serviced = 3'h0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [3:0] wb_adr = 4'h0;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] wb_dat_o, rd;
   logic wb_ack_o, irq_o, wake_o;
   logic [2:0] irq_req;
   logic pin_first, pin_second, pin_third;
   logic [7:0] bit_m;
   int num_errors = 0;
   int compares = 0;
   always #12.5 clk_sys = ~clk_sys;
   epis_pin_src i_epis_pin_src(.clk_sys(clk_sys), .pin_first(pin_first),
      .pin_second(pin_second), .pin_third(pin_third));
   epis_core i_epis_core(.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
      .io_clk_run(io_clk_run), .sleep_deep(sleep_deep),
      .startup_done(startup_done), .ext_irq_pin_first(pin_first),
      .ext_irq_pin_second(pin_second), .ext_irq_pin_third(pin_third),
      .irq_serviced(irq_serviced), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
      .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .irq_req(irq_req), .irq_o(irq_o), .wake_o(wake_o));
   task automatic conclude();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // Classic single cycle; the value read is taken at the ack edge
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [7:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_sys);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_dat <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (n >= 50) begin
         chk(1'b0, 1'b1, "bus ack timeout");
         conclude();
      end
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   initial begin
      #(25ns * 100000);
      chk(1'b0, 1'b1, "run timeout");
      conclude();
   end
   initial begin
      wait_clk(4);
      rst_b <= 1'b1;
      bus(1'b0, ADDR_SENSE, 8'h00, rd);
      chk(rd, {24'h0, SENSE_RESET}, "sense reset");
      bus(1'b0, ADDR_ENABLE, 8'h00, rd);
      chk(rd, {24'h0, ENABLE_RESET}, "enable reset");
      bus(1'b1, 4'h2, 8'hff, rd);
      bus(1'b0, 4'h2, 8'h00, rd);
      chk(rd, 32'h0, "unmapped read");
      bus(1'b1, ADDR_ENABLE, 8'he1, rd);
      bus(1'b0, ADDR_ENABLE, 8'h00, rd);
      chk(rd, 32'he1, "enable readback");
      // Each edge code on both pins: fall, then rise, sticky flag
      for (int p = 0; p < 2; p++) begin
         for (int c = 1; c < 4; c++) begin
            bit_m = 8'h01 << ((p == 0) ? BIT_FIRST : BIT_SECOND);
            bus(1'b1, ADDR_SENSE, 8'(c << (2 * p)), rd);
            wait_clk(8);
            bus(1'b1, ADDR_FLAG, 8'he0, rd);
            i_epis_pin_src.drive(p, 1'b0);
            wait_clk(8);
            bus(1'b0, ADDR_FLAG, 8'h00, rd);
            chk(rd, (c != 3) ? bit_m : 8'h0, "flag after fall");
            // Clear first, so a falling-only mode must ignore the rise
            bus(1'b1, ADDR_FLAG, 8'he0, rd);
            i_epis_pin_src.drive(p, 1'b1);
            wait_clk(8);
            bus(1'b0, ADDR_FLAG, 8'h00, rd);
            chk(rd, (c != 2) ? bit_m : 8'h0, "flag after rise");
         end
      end
      bus(1'b1, ADDR_FLAG, 8'he0, rd);
      bus(1'b1, ADDR_SENSE, 8'h00, rd);
      i_epis_pin_src.drive(0, 1'b0);
      wait_clk(8);
      chk(irq_o, 1'b1, "level request");
      chk(irq_req, 3'h1, "level request pin");
      bus(1'b0, ADDR_FLAG, 8'h00, rd);
      chk(rd, 32'h0, "level flag hidden");
      bus(1'b1, ADDR_ENABLE, 8'he0, rd);
      wait_clk(4);
      chk(irq_o, 1'b0, "global off");
      bus(1'b1, ADDR_ENABLE, 8'he1, rd);
      i_epis_pin_src.drive(0, 1'b1);
      wait_clk(8);
      chk(irq_o, 1'b0, "level released");
      // No I/O clock: third pin edges still seen, first pin edges not
      io_clk_run <= 1'b0;
      bus(1'b1, ADDR_SENSE, 8'h02, rd);
      bus(1'b1, ADDR_CSR, 8'h40, rd);
      bus(1'b1, ADDR_FLAG, 8'he0, rd);
      i_epis_pin_src.drive(0, 1'b0);
      i_epis_pin_src.drive(2, 1'b0);
      wait_clk(8);
      bus(1'b0, ADDR_FLAG, 8'h00, rd);
      chk(rd, 32'h0, "no edge without clock");
      i_epis_pin_src.drive(2, 1'b1);
      wait_clk(8);
      bus(1'b0, ADDR_FLAG, 8'h00, rd);
      chk(rd, 32'h20, "third rise");
      chk(irq_o, 1'b1, "third request");
      irq_serviced <= 3'h4;
      @(posedge clk_sys);
      irq_serviced <= 3'h0;
      bus(1'b0, ADDR_FLAG, 8'h00, rd);
      chk(rd, 32'h0, "service clears");
      i_epis_pin_src.drive(0, 1'b1);
      io_clk_run <= 1'b1;
      bus(1'b1, ADDR_SENSE, 8'h00, rd);
      // Enable low freezes all; then a third pin fall wakes deep sleep
      bus(1'b1, ADDR_CSR, 8'h00, rd);
      clk_en <= 1'b0;
      sleep_deep <= 1'b1;
      i_epis_pin_src.drive(2, 1'b0);
      wait_clk(8);
      chk(wake_o, 1'b0, "frozen by clock enable");
      clk_en <= 1'b1;
      wait_clk(8);
      chk(wake_o, 1'b1, "third pin wake");
      bus(1'b0, ADDR_FLAG, 8'h00, rd);
      chk(rd, 32'h20, "third fall");
      i_epis_pin_src.drive(2, 1'b1);
      sleep_deep <= 1'b0;
      bus(1'b1, ADDR_FLAG, 8'he0, rd);
      wait_clk(4);
      chk(irq_o, 1'b0, "third cleared by write");
      // Level wake, level gone before start-up ends
      sleep_deep <= 1'b1;
      startup_done <= 1'b0;
      i_epis_pin_src.drive(0, 1'b0);
      wait_clk(3 * WDOG_CYCLES);
      chk(wake_o, 1'b1, "level wake");
      i_epis_pin_src.drive(0, 1'b1);
      wait_clk(8);
      startup_done <= 1'b1;
      wait_clk(8);
      chk(irq_o, 1'b0, "wake without request");
      sleep_deep <= 1'b0;
      wait_clk(4);
      chk(wake_o, 1'b0, "wake dropped");
      conclude();
   end
endmodule // external_pin_interrupt_sense_test
